// file: hdl/preamp_ctrl_pkg.sv
// register map, field layout and reset values of the preamp control registers
package preamp_ctrl_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 6;

  // register indices into the offset, mask and reset tables
  localparam int IDX_CONV2 = 0;
  localparam int IDX_CONV3 = 1;
  localparam int IDX_CONV4 = 2;
  localparam int IDX_CONFIG = 3;
  localparam int IDX_GLOBAL = 4;
  localparam int IDX_PLL = 5;

  localparam logic [15:0] CONVERTER2_LEVEL_OFFSET = 16'h8435;
  localparam logic [15:0] CONVERTER3_LEVEL_OFFSET = 16'h8436;
  localparam logic [15:0] CONVERTER4_LEVEL_OFFSET = 16'h8437;
  localparam logic [15:0] CONVERTER_CONFIG_OFFSET_OFFSET = 16'h8438;
  localparam logic [15:0] GLOBAL_VIDEO_CONTROL_OFFSET = 16'h8439;
  localparam logic [15:0] PLL_RANGE_CONTROL_OFFSET = 16'h843e;

  localparam logic [15:0] REG_OFFSET [NUM_REGS] = '{
    CONVERTER2_LEVEL_OFFSET, CONVERTER3_LEVEL_OFFSET, CONVERTER4_LEVEL_OFFSET,
    CONVERTER_CONFIG_OFFSET_OFFSET, GLOBAL_VIDEO_CONTROL_OFFSET, PLL_RANGE_CONTROL_OFFSET
  };

  // implemented bits; reserved bits are dropped on write and read as zero
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    8'hff, 8'hff, 8'hff, 8'h7f, 8'h03, 8'h2f
  };

  // values after reset
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // converter configuration fields
  localparam int CFG_OFFSET_LSB = 0;
  localparam int CFG_OFFSET_MSB = 2;
  localparam int CFG_CONTRAST_LSB = 3;
  localparam int CFG_CONTRAST_MSB = 4;
  localparam int CFG_FULL_SCALE_BIT = 5;
  localparam int CFG_MIX_BIT = 6;

  // global video control fields
  localparam int GLB_BLANK_BIT = 0;
  localparam int GLB_POWER_BIT = 1;

  // pll range control fields
  localparam int PLL_RANGE_LSB = 0;
  localparam int PLL_RANGE_MSB = 1;
  localparam int PLL_VBLANK_BIT = 2;
  localparam int PLL_OVERRIDE_BIT = 3;
  localparam int PLL_CLAMP_BIT = 5;

endpackage : preamp_ctrl_pkg

// file: hdl/preamp_reg_cell.sv
// one masked read/write control register
`timescale 1ns/1ps
`default_nettype none

module preamp_reg_cell #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] BIT_MASK = '1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // write side
  input wire logic i_write,
  input wire logic [WIDTH-1:0] i_wdata,
  // stored value
  output logic [WIDTH-1:0] o_value
);

  logic [WIDTH-1:0] value_reg;

  // refuse a width the cell cannot hold
  if (WIDTH < 1) begin : g_bad_width
    $error("preamp_reg_cell: WIDTH must be at least 1");
  end

  // new value is live on the cycle after the write
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      value_reg <= RESET_VALUE & BIT_MASK;
    end else if (i_write) begin
      value_reg <= i_wdata & BIT_MASK;
    end
  end

  assign o_value = value_reg;

endmodule : preamp_reg_cell
`default_nettype wire

// file: hdl/preamp_control_registers.sv
// preamp control register bank driving converter and video controls
//
// Contract
// - converter2 output from its full 8-bit code
// - converter3 level register at 0x8436
// - converter4 level register at 0x8437
// - config bit5 picks 4.5V or 2.5V scale
// - config bit6 mixes half converter4 into others
// - config bits2-0 set video DC offset
// - config bits4-3 set overlay contrast
// - global bit0 forces video to black
// - global bit1 powers down analog sections
// - pll bits1-0 select pll frequency range
// - pll bit2 gates vertical blanking on video
// - pll bit3 shows overlay only, no video
// - pll bit5 selects clamp pulse polarity
`timescale 1ns/1ps
`default_nettype none

module preamp_control_registers #(
  parameter int ADDR_W = preamp_ctrl_pkg::ADDR_W,
  parameter int DATA_W = preamp_ctrl_pkg::DATA_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register access port
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  output logic [DATA_W-1:0] o_reg_rdata,
  output logic o_reg_ack,
  output logic o_reg_hit,
  // converter levels
  output logic [7:0] o_converter2_code,
  output logic [7:0] o_converter3_code,
  output logic [7:0] o_converter4_code,
  // converter configuration
  output logic o_full_scale_select,
  output logic o_converter4_mix_enable,
  output logic [2:0] o_video_black_offset,
  output logic [1:0] o_overlay_contrast,
  // global video control
  output logic o_blank_video,
  output logic o_power_save,
  // pll range control
  output logic [1:0] o_pll_range_select,
  output logic o_vblank_gate_enable,
  output logic o_overlay_only_override,
  output logic o_clamp_polarity
);

  localparam int NUM_REGS = preamp_ctrl_pkg::NUM_REGS;

  logic [NUM_REGS-1:0] sel;
  logic [7:0] value [NUM_REGS];
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] rdata_reg;
  logic ack_reg;
  logic hit_reg;

  // map and field layout only fit 16-bit addresses and byte data
  if (ADDR_W != 16) begin : g_bad_addr_w
    $error("preamp_control_registers: ADDR_W must be 16");
  end
  if (DATA_W != 8) begin : g_bad_data_w
    $error("preamp_control_registers: DATA_W must be 8");
  end

  // one cell per register, selected by exact address match
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      assign sel[g] = (i_reg_addr == preamp_ctrl_pkg::REG_OFFSET[g]);
      preamp_reg_cell #(
        .WIDTH(8),
        .RESET_VALUE(preamp_ctrl_pkg::REG_RESET[g]),
        .BIT_MASK(preamp_ctrl_pkg::REG_MASK[g])
      ) u_cell (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_write(i_reg_wr && sel[g]),
        .i_wdata(i_reg_wdata),
        .o_value(value[g])
      );
    end
  endgenerate

  // read mux; unmapped addresses read as zero
  always_comb begin
    rdata_next = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (sel[i]) begin
        rdata_next = value[i];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= '0;
    end else if (i_reg_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      ack_reg <= i_reg_wr || i_reg_rd;
      hit_reg <= (i_reg_wr || i_reg_rd) && (|sel);
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_ack = ack_reg;
  assign o_reg_hit = hit_reg;

  // converter levels
  assign o_converter2_code = value[preamp_ctrl_pkg::IDX_CONV2];
  assign o_converter3_code = value[preamp_ctrl_pkg::IDX_CONV3];
  assign o_converter4_code = value[preamp_ctrl_pkg::IDX_CONV4];

  // converter configuration fields
  assign o_full_scale_select =
    value[preamp_ctrl_pkg::IDX_CONFIG][preamp_ctrl_pkg::CFG_FULL_SCALE_BIT];
  assign o_converter4_mix_enable =
    value[preamp_ctrl_pkg::IDX_CONFIG][preamp_ctrl_pkg::CFG_MIX_BIT];
  assign o_video_black_offset = value[preamp_ctrl_pkg::IDX_CONFIG]
    [preamp_ctrl_pkg::CFG_OFFSET_MSB:preamp_ctrl_pkg::CFG_OFFSET_LSB];
  assign o_overlay_contrast = value[preamp_ctrl_pkg::IDX_CONFIG]
    [preamp_ctrl_pkg::CFG_CONTRAST_MSB:preamp_ctrl_pkg::CFG_CONTRAST_LSB];

  // global video control
  assign o_blank_video =
    value[preamp_ctrl_pkg::IDX_GLOBAL][preamp_ctrl_pkg::GLB_BLANK_BIT];
  assign o_power_save =
    value[preamp_ctrl_pkg::IDX_GLOBAL][preamp_ctrl_pkg::GLB_POWER_BIT];

  // pll range control
  assign o_pll_range_select = value[preamp_ctrl_pkg::IDX_PLL]
    [preamp_ctrl_pkg::PLL_RANGE_MSB:preamp_ctrl_pkg::PLL_RANGE_LSB];
  assign o_vblank_gate_enable =
    value[preamp_ctrl_pkg::IDX_PLL][preamp_ctrl_pkg::PLL_VBLANK_BIT];
  assign o_overlay_only_override =
    value[preamp_ctrl_pkg::IDX_PLL][preamp_ctrl_pkg::PLL_OVERRIDE_BIT];
  assign o_clamp_polarity =
    value[preamp_ctrl_pkg::IDX_PLL][preamp_ctrl_pkg::PLL_CLAMP_BIT];

endmodule : preamp_control_registers
`default_nettype wire

// file: sim/preamp_control_registers_assertions.sv
// timing and field checks on the preamp register bank ports
`timescale 1ns/1ps
`default_nettype none
module preamp_control_registers_chk (
  // watched ports
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic o_reg_ack,
  input wire logic o_reg_hit,
  input wire logic [7:0] o_converter3_code,
  input wire logic o_full_scale_select,
  input wire logic o_converter4_mix_enable,
  input wire logic o_blank_video,
  input wire logic o_clamp_polarity
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  ack_follow_a: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack) else $error("no ack");
  ack_only_a: assert property (!(i_reg_wr || i_reg_rd) |=> !o_reg_ack) else $error("stray ack");
  conv3_hit_a: assert property (i_reg_rd && i_reg_addr == 16'h8436 |=> o_reg_hit) else $error("miss");
  conv3_code_a: assert property (i_reg_wr && i_reg_addr == 16'h8436
    |=> o_converter3_code == $past(i_reg_wdata)) else $error("code");
  blank_bit_a: assert property (i_reg_wr && i_reg_addr == 16'h8439
    |=> o_blank_video == $past(i_reg_wdata[0])) else $error("blank");
  scale_bit_a: assert property (i_reg_wr && i_reg_addr == 16'h8438
    |=> o_full_scale_select == $past(i_reg_wdata[5])) else $error("scale");
  mix_bit_a: assert property (i_reg_wr && i_reg_addr == 16'h8438
    |=> o_converter4_mix_enable == $past(i_reg_wdata[6])) else $error("mix");
  clamp_bit_a: assert property (i_reg_wr && i_reg_addr == 16'h843e
    |=> o_clamp_polarity == $past(i_reg_wdata[5])) else $error("clamp");
  cover property (i_reg_wr && i_reg_rd);
  cover property (o_reg_ack && !o_reg_hit);
  cover property (i_reg_wr ##1 i_reg_rd);
endmodule : preamp_control_registers_chk
`default_nettype wire

// file: sim/tb_preamp_control_registers.sv
// self-checking bench for the preamp register bank
`timescale 1ns/1ps
`default_nettype none
module tb_preamp_control_registers;
  logic i_clk = 0, i_rst_b = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic [15:0] i_reg_addr = '0;
  logic [7:0] i_reg_wdata = '0, o_reg_rdata, o_converter2_code, o_converter3_code;
  logic [7:0] o_converter4_code;
  logic o_reg_ack, o_reg_hit, o_full_scale_select, o_converter4_mix_enable, o_blank_video;
  logic o_power_save, o_vblank_gate_enable, o_overlay_only_override, o_clamp_polarity;
  logic [2:0] o_video_black_offset;
  logic [1:0] o_overlay_contrast, o_pll_range_select;
  logic [9:0] q[$];
  logic [9:0] nt;
  logic [7:0] sh[6] = '{default: '0};
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  preamp_control_registers DUT (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_ack(o_reg_ack),
    .o_reg_hit(o_reg_hit),
    .o_converter2_code(o_converter2_code),
    .o_converter3_code(o_converter3_code),
    .o_converter4_code(o_converter4_code),
    .o_full_scale_select(o_full_scale_select),
    .o_converter4_mix_enable(o_converter4_mix_enable),
    .o_video_black_offset(o_video_black_offset),
    .o_overlay_contrast(o_overlay_contrast),
    .o_blank_video(o_blank_video),
    .o_power_save(o_power_save),
    .o_pll_range_select(o_pll_range_select),
    .o_vblank_gate_enable(o_vblank_gate_enable),
    .o_overlay_only_override(o_overlay_only_override),
    .o_clamp_polarity(o_clamp_polarity)
  );
  initial forever #2.5 i_clk = ~i_clk;
  task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // one request per call, strobes left up for back-to-back use
  task automatic acc(logic w, logic r, logic [15:0] a, logic [7:0] d, logic [7:0] e, logic h);
    @(negedge i_clk);
    i_reg_wr = w;
    i_reg_rd = r;
    i_reg_addr = a;
    i_reg_wdata = d;
    q.push_back({r, h, e});
  endtask : acc
  task automatic idle();
    @(negedge i_clk);
    i_reg_wr = 0;
    i_reg_rd = 0;
  endtask : idle
  task automatic outs();
    chk("ctl", {sh[0], sh[1], sh[2], sh[3][6:0], sh[4][1:0], sh[5][5], sh[5][3:0]},
      {o_converter2_code, o_converter3_code, o_converter4_code, o_converter4_mix_enable,
      o_full_scale_select, o_overlay_contrast, o_video_black_offset, o_power_save, o_blank_video,
      o_clamp_polarity, o_overlay_only_override, o_vblank_gate_enable, o_pll_range_select});
  endtask : outs
  task automatic finish_test();
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // result watcher
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 2000) begin
      n_mismatch++;
      finish_test();
    end else if (o_reg_ack === 1'b1) begin
      if (q.size() == 0) begin
        chk("queue", 1, 0);
      end else begin
        nt = q.pop_front();
        chk("hit", nt[8], o_reg_hit);
        if (nt[9]) chk("rdata", nt[7:0], o_reg_rdata);
      end
    end
  end
  initial begin
    void'($urandom(32'h5637));
    repeat (3) @(posedge i_clk);
    @(negedge i_clk) i_rst_b = 1;
    for (int i = 0; i < 6; i++) acc(0, 1, preamp_ctrl_pkg::REG_OFFSET[i], 0, 0, 1);
    for (int k = 0; k < 60; k++) begin
      int i;
      logic [7:0] d;
      i = $urandom_range(5);
      d = 8'($urandom) & preamp_ctrl_pkg::REG_MASK[i];
      acc(1, 1, preamp_ctrl_pkg::REG_OFFSET[i], d, sh[i], 1);
      sh[i] = d & preamp_ctrl_pkg::REG_MASK[i];
      acc(0, 1, preamp_ctrl_pkg::REG_OFFSET[i], 0, sh[i], 1);
      if (k % 10 == 9) begin
        idle();
        outs();
      end
    end
    acc(1, 0, 16'h843a, 8'hff, 0, 0);
    acc(0, 1, 16'h843a, 0, 0, 0);
    idle();
    outs();
    @(negedge i_clk) i_rst_b = 0;
    sh = '{default: '0};
    @(negedge i_clk) outs();
    i_rst_b = 1;
    repeat (2) idle();
    chk("pending", 0, q.size());
    finish_test();
  end
endmodule : tb_preamp_control_registers
bind preamp_control_registers preamp_control_registers_chk chk_i (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd),
  .i_reg_wdata(i_reg_wdata),
  .o_reg_ack(o_reg_ack),
  .o_reg_hit(o_reg_hit),
  .o_converter3_code(o_converter3_code),
  .o_full_scale_select(o_full_scale_select),
  .o_converter4_mix_enable(o_converter4_mix_enable),
  .o_blank_video(o_blank_video),
  .o_clamp_polarity(o_clamp_polarity)
);
`default_nettype wire
